// [rtl/lfm_ctrl.sv]
`timescale 1ns/1ps
// What this block does
// RQ1 - Both mode selects low: power stage shut down, no regulation.
// RQ2 - Mode 01: LED on at torch level, current regulation.
// RQ3 - Mode 10: flash operation enabled, current regulation.
// RQ4 - Mode 11: LED off, voltage regulation to 5.0 V.
// RQ5 - Strobe high in flash mode drives flash level, no added latency.
// RQ6 - Each strobe rising edge starts an 820 ms safety timer.
// RQ7 - Timer stops on strobe fall or timeout, whichever first.
// RQ8 - After timeout stay at torch until strobe falls and rises again.
// RQ9 - Blanking input high drops flash to torch at once.
// RQ10 - Blanking neither pauses nor extends the safety timer.
// RQ11 - Low-light dimming gates torch current with a 122 Hz PWM.
// RQ12 - Dimming PWM on time is 6.3 percent.
// RQ13 - Dimming only in torch-only mode with strobe high.
// RQ14 - Host blinks the LED by toggling the dimmer enable bit.
// RQ15 - Leaving shutdown switches at once and ramps reference gently.
// RQ16 - Shutdown: no switching, transistors off, LED pin high impedance.
// RQ17 - Operating converter switches at constant 2 MHz; the code divides 25 MHz by 12, about 2.08 MHz.
// RQ18 - Blanking high forces torch operation; low runs normally.
// RQ19 - Thermal shutdown stays off until a shutdown phase is seen.
module lfm_ctrl #(
   parameter int unsigned SAFETY_CYC = lfm_pkg::SAFETY_CYC,
   parameter int unsigned DIM_PERIOD = lfm_pkg::DIM_PERIOD_CYC,
   parameter int unsigned DIM_ON     = lfm_pkg::DIM_ON_CYC
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        op_select_lo_i,
   input  wire logic        op_select_hi_i,
   input  wire logic        flash_strobe_i,
   input  wire logic        tx_blank_in_i,
   input  wire logic        over_temp_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output lfm_pkg::lfm_drive_s drive_o,
   output logic             sw_clk_o
);
   // Pin inputs pass two flops before use
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1_r <= 5'h00;
         sync2_r <= 5'h00;
      end
      else if (ce_i)
      begin
         sync1_r <= {over_temp_i, tx_blank_in_i, flash_strobe_i,
                     op_select_hi_i, op_select_lo_i};
         sync2_r <= sync1_r;
      end
   end

   lfm_pkg::lfm_mode_e mode;
   logic strobe;
   logic blank;
   logic hot;

   assign mode   = lfm_pkg::lfm_mode_e'(sync2_r[1:0]);
   assign strobe = sync2_r[2];
   assign blank  = sync2_r[3];
   assign hot    = sync2_r[4];

   // Control register: dimmer enable bit
   logic [1:0]  ctrl_r;
   logic        ovt_r;
   logic        ack_r;
   logic [31:0] rdat_r;
   logic        req;

   assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_r <= 1'b0;
      else
         ack_r <= req;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctrl_r <= lfm_pkg::CTRL_RST;
      else if (req && wb_we_i && wb_sel_i[0] &&
               wb_adr_i == lfm_pkg::ADDR_CTRL)
         ctrl_r[lfm_pkg::CTRL_DIM_BIT] <= wb_dat_i[lfm_pkg::CTRL_DIM_BIT];
   end

   logic       led_act;
   logic       flash_lvl;
   logic       dim_gate;
   logic       flash_ok;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdat_r <= 32'h0000_0000;
      else if (req && !wb_we_i)
      begin
         if (wb_adr_i == lfm_pkg::ADDR_CTRL)
            rdat_r <= {30'h0, ovt_r, ctrl_r[lfm_pkg::CTRL_DIM_BIT]};
         else if (wb_adr_i == lfm_pkg::ADDR_STAT)
            rdat_r <= {24'h0, ovt_r, dim_gate, flash_lvl, led_act,
                       blank, strobe, sync2_r[1:0]};
         else
            rdat_r <= 32'h0000_0000;
      end
   end

   // Thermal latch clears only when a shutdown phase is seen
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ovt_r <= 1'b0;
      else if (ce_i)
      begin
         if (hot)
            ovt_r <= 1'b1; // RQ19
         else if (mode == lfm_pkg::LFM_SHUTDOWN)
            ovt_r <= 1'b0; // RQ19
      end
   end

   logic active;
   assign active = (mode != lfm_pkg::LFM_SHUTDOWN) & ~ovt_r;

   lfm_safety_timer #(
      .TIMEOUT_CYC (SAFETY_CYC)
   ) u_timer (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .strobe_i   (strobe),
      .arm_i      (active && mode == lfm_pkg::LFM_FLASH),
      .flash_ok_o (flash_ok),
      .expired_o  ()
   );

   logic dim_run;
   // RQ13
   assign dim_run = active && mode == lfm_pkg::LFM_TORCH && strobe &&
                    ctrl_r[lfm_pkg::CTRL_DIM_BIT];

   lfm_dim_pwm #(
      .PERIOD_CYC (DIM_PERIOD),
      .ON_CYC     (DIM_ON)
   ) u_dim (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .run_i  (dim_run),
      .gate_o (dim_gate)
   );

   // Flash level is combinational from synced pins, no extra latency
   // RQ5 RQ9 RQ18
   assign flash_lvl = active && mode == lfm_pkg::LFM_FLASH &&
                      flash_ok && !blank;

   always_comb
   begin
      led_act = 1'b0;
      if (active)
      begin
         unique case (mode)
            lfm_pkg::LFM_TORCH:   led_act = dim_run ? dim_gate : 1'b1; // RQ2
            lfm_pkg::LFM_FLASH:   led_act = 1'b1; // RQ3
            lfm_pkg::LFM_VOLTAGE: led_act = 1'b0; // RQ4
            lfm_pkg::LFM_SHUTDOWN: led_act = 1'b0; // RQ1
         endcase
      end
   end

   // Soft-start reference ramp, restarts from zero on each shutdown
   logic [7:0] ref_r;
   logic [3:0] step_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i || !active)
      begin
         ref_r  <= 8'h00;
         step_r <= 4'h0;
      end
      else if (ce_i && ref_r != lfm_pkg::REF_FULL)
      begin
         step_r <= step_r + 4'h1;
         if (step_r == 4'(lfm_pkg::REF_STEP_CYC - 1))
            ref_r <= ref_r + 8'h01; // RQ15
      end
   end

   // 2 MHz switching clock; 25/2 is not integral, period rounds to 12
   localparam int SWW = $clog2(lfm_pkg::SW_PERIOD_CYC);
   logic [SWW-1:0] sw_cnt_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i || !active)
         sw_cnt_r <= '0; // RQ16
      else if (ce_i)
      begin
         if (sw_cnt_r == SWW'(lfm_pkg::SW_PERIOD_CYC - 1))
            sw_cnt_r <= '0; // RQ17
         else
            sw_cnt_r <= sw_cnt_r + SWW'(1);
      end
   end

   assign sw_clk_o = active && (sw_cnt_r < SWW'(lfm_pkg::SW_PERIOD_CYC / 2));

   always_comb
   begin
      drive_o.switching          = active; // RQ15 RQ16
      drive_o.current_regulation = active && (mode == lfm_pkg::LFM_TORCH ||
                                   mode == lfm_pkg::LFM_FLASH);
      drive_o.voltage_regulation = active && mode == lfm_pkg::LFM_VOLTAGE;
      drive_o.led_on             = led_act;
      drive_o.flash_level        = flash_lvl;
      drive_o.led_hiz            = !active; // RQ16
      drive_o.ref_level          = ref_r;
   end

   a_shutdown_off : assert property ( // RQ1
      @(posedge clk_i) disable iff (rst_i)
      mode == lfm_pkg::LFM_SHUTDOWN |-> !drive_o.switching && drive_o.led_hiz
      && !sw_clk_o)
      else $error("activity in shutdown");
   a_volt_led_off : assert property ( // RQ4
      @(posedge clk_i) disable iff (rst_i)
      active && mode == lfm_pkg::LFM_VOLTAGE |-> drive_o.voltage_regulation
      && !drive_o.led_on)
      else $error("voltage mode with LED on");
   a_blank_torch : assert property ( // RQ9
      @(posedge clk_i) disable iff (rst_i)
      blank |-> !drive_o.flash_level)
      else $error("flash level while blanked");
   a_torch_no_flash : assert property ( // RQ2
      @(posedge clk_i) disable iff (rst_i)
      mode == lfm_pkg::LFM_TORCH && active && !dim_run |-> drive_o.led_on
      && !drive_o.flash_level && drive_o.current_regulation)
      else $error("torch mode wrong drive");
   a_dim_only_torch : assert property ( // RQ13
      @(posedge clk_i) disable iff (rst_i)
      mode != lfm_pkg::LFM_TORCH |-> !dim_run)
      else $error("dimming outside torch mode");
   a_thermal_hold : assert property ( // RQ19
      @(posedge clk_i) disable iff (rst_i)
      ovt_r && mode != lfm_pkg::LFM_SHUTDOWN |-> !drive_o.switching)
      else $error("running after thermal trip");
   a_hot_latch : assert property ( // RQ19
      @(posedge clk_i) disable iff (rst_i)
      ce_i && hot |=> ovt_r)
      else $error("thermal latch not set");
   a_flash_strobe : assert property ( // RQ5
      @(posedge clk_i) disable iff (rst_i)
      active && mode == lfm_pkg::LFM_FLASH && $rose(strobe) && !blank
      && ce_i |-> drive_o.flash_level)
      else $error("strobe rise without flash level");
   // Leaving operation right after phase zero is legal, so ask for active
   a_sw_period : assert property ( // RQ17
      @(posedge clk_i) disable iff (rst_i)
      ce_i && active && sw_cnt_r == '0 ##1 active |-> sw_clk_o)
      else $error("switch clock phase wrong");
   a_ref_start : assert property ( // RQ15
      @(posedge clk_i) disable iff (rst_i)
      $rose(active) |-> ref_r == 8'h00)
      else $error("reference not restarted");

   c_flash : cover property (@(posedge clk_i) drive_o.flash_level);
   c_blank : cover property (@(posedge clk_i)
      mode == lfm_pkg::LFM_FLASH && strobe && blank);
   c_dim   : cover property (@(posedge clk_i) dim_run && dim_gate);
   c_hot   : cover property (@(posedge clk_i) $fell(ovt_r));
endmodule

// [rtl/lfm_dim_pwm.sv]
`timescale 1ns/1ps
module lfm_dim_pwm #(
   parameter int unsigned PERIOD_CYC = lfm_pkg::DIM_PERIOD_CYC,
   parameter int unsigned ON_CYC     = lfm_pkg::DIM_ON_CYC
)(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic run_i,
   output logic      gate_o
);
   localparam int W = $clog2(PERIOD_CYC);

   logic [W-1:0] cnt_r;

   // Restart from phase zero so each blink begins with an on slot
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !run_i)
         cnt_r <= '0;
      else if (ce_i)
      begin
         if (cnt_r == W'(PERIOD_CYC - 1))
            cnt_r <= '0; // RQ11
         else
            cnt_r <= cnt_r + W'(1);
      end
   end

   assign gate_o = run_i & (cnt_r < W'(ON_CYC)); // RQ12

   a_dim_duty : assert property ( // RQ12
      @(posedge clk_i) disable iff (rst_i)
      run_i && cnt_r == W'(ON_CYC) |-> !gate_o)
      else $error("dim gate on past duty window");
endmodule

// [rtl/lfm_pkg.sv]
package lfm_pkg;

   // System clock rate
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned CLK_PERIOD_NS  = 40;

   // Flash safety timeout, in milliseconds
   localparam int unsigned SAFETY_MS      = 820;
   localparam int unsigned SAFETY_CYC     = SAFETY_MS * (CLK_HZ / 1000);

   // Dimming PWM: 122 Hz, 6.3 % on time (in tenths of a percent)
   localparam int unsigned DIM_HZ         = 122;
   localparam int unsigned DIM_DUTY_PM    = 63;
   localparam int unsigned DIM_PERIOD_CYC = CLK_HZ / DIM_HZ;
   localparam int unsigned DIM_ON_CYC     = DIM_PERIOD_CYC * DIM_DUTY_PM / 1000;

   // Converter switching: 2 MHz
   localparam int unsigned SW_HZ          = 2_000_000;
   localparam int unsigned SW_PERIOD_CYC  = CLK_HZ / SW_HZ;

   // Soft-start reference ramp
   localparam int unsigned REF_W          = 8;
   localparam logic [7:0]  REF_FULL       = 8'hFF;
   localparam int unsigned REF_STEP_CYC   = 16;

   // Wishbone register map, byte addresses
   localparam logic [3:0]  ADDR_CTRL      = 4'h0;
   localparam logic [3:0]  ADDR_STAT      = 4'h4;
   localparam int unsigned CTRL_DIM_BIT   = 0;
   localparam int unsigned CTRL_OVT_BIT   = 1;
   localparam logic [1:0]  CTRL_RST       = 2'h0;

   // Mode select encoding {hi, lo}
   typedef enum logic [1:0]
   {
      LFM_SHUTDOWN = 2'b00,
      LFM_TORCH    = 2'b01,
      LFM_FLASH    = 2'b10,
      LFM_VOLTAGE  = 2'b11
   } lfm_mode_e;

   // Drive state presented to the analog stage
   typedef struct packed
   {
      logic       switching;
      logic       current_regulation;
      logic       voltage_regulation;
      logic       led_on;
      logic       flash_level;
      logic       led_hiz;
      logic [7:0] ref_level;
   } lfm_drive_s;

endpackage

// [rtl/lfm_safety_timer.sv]
`timescale 1ns/1ps
module lfm_safety_timer #(
   parameter int unsigned TIMEOUT_CYC = lfm_pkg::SAFETY_CYC
)(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic strobe_i,
   input  wire logic arm_i,
   output logic      flash_ok_o,
   output logic      expired_o
);
   localparam int W = $clog2(TIMEOUT_CYC + 1);

   logic [W-1:0] cnt_r;
   logic         run_r;
   logic         exp_r;
   logic         strobe_d_r;
   logic         rise;

   assign rise = strobe_i & ~strobe_d_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         strobe_d_r <= 1'b0;
      else if (ce_i)
         strobe_d_r <= strobe_i;
   end

   // Blanking does not reach here, so masking never pauses the count
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !arm_i)
      begin
         cnt_r <= '0;
         run_r <= 1'b0;
         exp_r <= 1'b0;
      end
      else if (ce_i)
      begin
         if (rise)
         begin
            cnt_r <= '0; // RQ6
            run_r <= 1'b1;
            exp_r <= 1'b0;
         end
         else if (!strobe_i)
         begin
            run_r <= 1'b0; // RQ7
            exp_r <= 1'b0; // RQ8
         end
         else if (run_r)
         begin
            if (cnt_r == W'(TIMEOUT_CYC - 1))
            begin
               run_r <= 1'b0; // RQ7
               exp_r <= 1'b1; // RQ8
            end
            else
               cnt_r <= cnt_r + W'(1); // RQ10
         end
      end
   end

   assign flash_ok_o = strobe_i & ~exp_r;
   assign expired_o  = exp_r;

   a_timeout_hold : assert property ( // RQ8
      @(posedge clk_i) disable iff (rst_i)
      exp_r && strobe_i && ce_i && arm_i && !rise |=> exp_r)
      else $error("expired flag dropped while strobe high");
endmodule

// [verification/led_flash_mode_control_bench.sv]
`timescale 1ns/1ps
module led_flash_mode_control_bench;
   // Short counts keep the run brief; expectations follow these
   localparam int unsigned PER = 100;
   localparam int unsigned ON  = 6;
   // {mode, strobe, blank, switching, creg, vreg, led_on, flash, hiz}
   localparam logic [9:0] ROWS [8] = '{
      10'b00_0_0_000001, 10'b01_0_0_110100, 10'b01_1_0_110100,
      10'b10_0_0_110100, 10'b10_1_0_110110, 10'b10_1_1_110100,
      10'b11_0_0_101000, 10'b11_1_0_101000};
   logic                clk_i = 1'b0;
   logic                rst_i = 1'b1;
   logic                ce    = 1'b1;
   logic                ot    = 1'b0;
   logic                cyc   = 1'b0;
   logic                stb   = 1'b0;
   logic                we    = 1'b0;
   logic [3:0]          adr   = 4'h0;
   logic [3:0]          sel   = 4'h0;
   logic [31:0]         dat   = 32'h0;
   logic [1:0]          mode  = 2'h0;
   logic                strb  = 1'b0;
   logic                blk   = 1'b0;
   logic                lo;
   logic                hi;
   logic                fs;
   logic                tb;
   logic [31:0]         rd;
   logic                ack;
   lfm_pkg::lfm_drive_s drv;
   logic                sw;
   logic [31:0]         q;
   int                  k;
   int                  fail_count = 0;
   int                  n_checks = 0;
   int                  cyc_n = 0;

   always #20 clk_i = ~clk_i;

   lfm_host_model host (.clk_i(clk_i), .mode_i(mode), .strobe_i(strb),
      .blank_i(blk), .lo_o(lo), .hi_o(hi), .strobe_o(fs), .blank_o(tb));

   lfm_ctrl #(.SAFETY_CYC(200), .DIM_PERIOD(PER), .DIM_ON(ON)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .op_select_lo_i(lo),
      .op_select_hi_i(hi), .flash_strobe_i(fs), .tx_blank_in_i(tb),
      .over_temp_i(ot), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
      .wb_ack_o(ack), .drive_o(drv), .sw_clk_o(sw));

   task automatic final_report();
      if (fail_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Pins pass the host flop and a two-flop sync before use
   task automatic pins(input logic [1:0] m, input logic s, input logic b,
                       input int w);
      @(posedge clk_i);
      mode <= m;
      strb <= s;
      blk  <= b;
      repeat (w) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   // Ack is sampled at a rising edge; data taken and request dropped there
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= 4'hF;
      dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      r = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // Counts led_on samples, or rising switching edges when s is set
   task automatic cnt(input int n, input logic s, output int c);
      logic p;
      p = sw;
      c = 0;
      repeat (n)
      begin
         @(negedge clk_i);
         c += s ? int'(sw && !p) : int'(drv.led_on);
         p = sw;
      end
   endtask

   always @(posedge clk_i)
   begin
      cyc_n++;
      if (cyc_n == 40000)
      begin
         fail_count++;
         final_report();
      end
   end

   initial
   begin
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      chk("reset drive", 32'h01, drv[13:8]);
      chk("reset swclk", 32'h0, sw);
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         pins(ROWS[i][9:8], ROWS[i][7], ROWS[i][6], 4);
         chk("drive", ROWS[i][5:0], drv[13:8]);
      end
      pins(2'b00, 1'b0, 1'b0, 4);
      chk("shut ref", 32'h0, drv.ref_level);
      cnt(24, 1'b1, k);
      chk("shut sw edges", 32'h0, k);
      pins(2'b01, 1'b0, 1'b0, 3);
      chk("start switching", 32'h1, drv.switching);
      cnt(120, 1'b1, k);
      chk("sw edges", 32'd10, k);
      chk("ramp partial", 32'h1, drv.ref_level < 8'hFF);
      repeat (4200) @(posedge clk_i);
      @(negedge clk_i);
      chk("ramp full", 32'hFF, drv.ref_level);
      pins(2'b01, 1'b1, 1'b0, 4);
      wb(1'b1, 4'h0, 32'h1, q);
      wb(1'b0, 4'h0, 32'h0, q);
      chk("ctrl dim", 32'h1, q[0]);
      cnt(PER, 1'b0, k);
      chk("dim on", ON, k);
      cnt(2 * PER, 1'b0, k);
      chk("dim on 2", 2 * ON, k);
      wb(1'b1, 4'h0, 32'h0, q);
      cnt(PER, 1'b0, k);
      chk("dim off", PER, k);
      wb(1'b1, 4'h8, 32'h0, q);
      wb(1'b0, 4'h8, 32'h0, q);
      chk("unmapped", 32'h0, q);
      wb(1'b1, 4'h0, 32'h1, q);
      pins(2'b10, 1'b0, 1'b0, 4);
      cnt(PER, 1'b0, k);
      chk("no dim flash", PER, k);
      pins(2'b10, 1'b1, 1'b0, 4);
      pins(2'b10, 1'b1, 1'b1, 40);
      chk("blanked", 32'h0, drv.flash_level);
      pins(2'b10, 1'b1, 1'b0, 100);
      pins(2'b10, 1'b1, 1'b0, 38);
      chk("before timeout", 32'h1, drv.flash_level);
      repeat (30) @(posedge clk_i);
      @(negedge clk_i);
      chk("after timeout", 32'h0, drv.flash_level);
      chk("torch held", 32'h1, drv.led_on);
      pins(2'b10, 1'b0, 1'b0, 4);
      pins(2'b10, 1'b1, 1'b0, 4);
      chk("rearmed", 32'h1, drv.flash_level);
      pins(2'b10, 1'b0, 1'b0, 50);
      pins(2'b10, 1'b1, 1'b0, 150);
      chk("restart", 32'h1, drv.flash_level);
      pins(2'b01, 1'b0, 1'b0, 4);
      @(posedge clk_i);
      ot <= 1'b1;
      repeat (4) @(posedge clk_i);
      ot <= 1'b0;
      pins(2'b01, 1'b0, 1'b0, 4);
      chk("hot off", 32'h0, drv.switching);
      wb(1'b0, 4'h4, 32'h0, q);
      chk("stat hot", 32'h81, q);
      wb(1'b0, 4'h0, 32'h0, q);
      chk("ctrl hot", 32'h3, q);
      pins(2'b00, 1'b0, 1'b0, 4);
      pins(2'b01, 1'b0, 1'b0, 4);
      chk("resumed", 32'h1, drv.switching);
      @(posedge clk_i);
      ce <= 1'b0;
      pins(2'b00, 1'b0, 1'b0, 4);
      chk("ce freeze", 32'h1, drv.switching);
      @(posedge clk_i);
      ce <= 1'b1;
      pins(2'b00, 1'b0, 1'b0, 4);
      chk("ce resume", 32'h0, drv.switching);
      final_report();
   end
endmodule

// [verification/lfm_host_model.sv]
`timescale 1ns/1ps
// Host GPIOs and camera strobe; pins move only just after a rising edge
module lfm_host_model (
   input  wire logic       clk_i,
   input  wire logic [1:0] mode_i,
   input  wire logic       strobe_i,
   input  wire logic       blank_i,
   output logic            lo_o,
   output logic            hi_o,
   output logic            strobe_o,
   output logic            blank_o
);
   // Shutdown phase is simply mode 00 held by the host
   always @(posedge clk_i)
   begin
      {hi_o, lo_o} <= mode_i;
      strobe_o     <= strobe_i;
      blank_o      <= blank_i;
   end
endmodule
